/* File: common/acrpc_defs.svh */
/*
 * Offsets, field positions, reset values and timing counts of the
 * converter control block. Assumes plain textual inclusion.
 */
`ifndef ACRPC_DEFS_SVH
`define ACRPC_DEFS_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define ACRPC_IDX_PIN_CFG    8'hAE
`define ACRPC_IDX_CTRL       8'hB1
`define ACRPC_IDX_RES_HI     8'hB2
`define ACRPC_IDX_CLK_RES_LO 8'hB3
`define ACRPC_IDX_IRQ_STAT   8'hC0
`define ACRPC_IDX_IRQ_MASK   8'hC1

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ACRPC_CTRL_EN        7
`define ACRPC_CTRL_START     6
`define ACRPC_CTRL_DONE      5
`define ACRPC_CTRL_CHANNEL_GLOBAL_ENABLE      4
`define ACRPC_CLK_SEL_HI     6
`define ACRPC_CLK_SEL_LO     4
`define ACRPC_IRQ_DONE       0
`define ACRPC_IRQ_ABORT      1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ACRPC_RST_BYTE       8'h00

// ----------------------------------------
// Clock divisors minus one, and conversion timing
// ----------------------------------------
`define ACRPC_DIV16_LIM      4'hF
`define ACRPC_DIV8_LIM       4'h7
`define ACRPC_DIV1_LIM       4'h0
`define ACRPC_DIV2_LIM       4'h1
`define ACRPC_STEPS          16
`define ACRPC_CLKS_PER_STEP  4
`define ACRPC_SAMPLE_STEPS   4'h4
`define ACRPC_LAST_TICK      6'h3F

`endif

/* File: common/acrpc_pkg.sv */
/*
 * Types of the converter control block: state enums and state structs.
 * Assumes acrpc_defs.svh for numeric constants.
 */
package acrpc_pkg;

	typedef logic [11:0] acrpc_res_t;
	typedef logic [7:0]  acrpc_byte_t;

	typedef enum logic { BUS_IDLE, BUS_ACK } acrpc_bus_e;
	typedef enum logic { SAR_IDLE, SAR_RUN } acrpc_sar_e;

	typedef struct packed {
		acrpc_bus_e  bus_st;
		acrpc_byte_t rdata;
		logic        en;
		logic        start;
		logic        done;
		logic        channel_global_enable;
		logic [2:0]  channel_select;
		logic [1:0]  clk_sel;
		logic [4:0]  pin_cfg;
		logic [1:0]  irq_stat;
		logic [1:0]  irq_mask;
		logic [3:0]  div_cnt;
		logic        comp_s1;
		logic        comp_s2;
	} acrpc_top_s;

	typedef struct packed {
		acrpc_sar_e st;
		logic [5:0] cnt;
		acrpc_res_t code;
		acrpc_res_t res;
		logic       done;
	} acrpc_sar_s;

endpackage : acrpc_pkg

/* File: hw/acrpc_sar.sv */
/*
 * Successive approximation sequencer: 16 steps of 4 conversion clocks,
 * 4 sampling steps then one decision per bit, MSB first.
 * Assumes a synchronised comparator level and a conversion clock tick.
 */
module acrpc_sar
	import acrpc_pkg::*;
(
	input  wire logic            mclk_in,     // Instruction clock
	input  wire logic            sys_rst_in,  // Async reset, high
	input  wire logic            ce_in,       // Clock enable
	input  wire logic            tick_in,     // Conversion clock tick
	input  wire logic            go_in,       // Start pulse
	input  wire logic            abort_in,    // Stop sequence
	input  wire logic            comp_in,     // Input >= trial level
	output logic                 busy_out,    // Sequence running
	output logic                 sample_out,  // Sampling phase
	output logic                 done_out,    // One-cycle completion
	output acrpc_pkg::acrpc_res_t code_out,   // Trial code to DAC
	output acrpc_pkg::acrpc_res_t res_out     // Final code
);
	`include "acrpc_defs.svh"

	acrpc_sar_s q, d;
	logic [3:0] step;
	acrpc_res_t trial;

	assign step = q.cnt[5:2];
	assign trial = 12'(12'h001 << (4'hF - step));

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb
	begin
		d = q;
		d.done = 1'b0;
		case (q.st)
			SAR_IDLE:
			begin
				if (go_in)
				begin
					d.st = SAR_RUN;
					d.cnt = 6'h00;
					d.code = 12'h800;
				end
			end
			SAR_RUN:
			begin
				if (abort_in)
					d.st = SAR_IDLE;
				else if (tick_in)
				begin
					d.cnt = q.cnt + 6'h01;
					if (q.cnt[1:0] == 2'h3 && step >= `ACRPC_SAMPLE_STEPS)
					begin
						if (!comp_in)
							d.code = q.code & ~trial;
						d.code = d.code | (trial >> 1);
					end
					if (q.cnt == `ACRPC_LAST_TICK)
					begin
						d.st = SAR_IDLE;
						d.res = d.code;
						d.done = 1'b1;
					end
				end
			end
			default: d.st = SAR_IDLE;
		endcase
	end

	// State register; reset clears the whole state, result included
	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			q <= '0;
		else if (ce_in)
			q <= d;
	end

	assign busy_out = (q.st == SAR_RUN);
	assign sample_out = busy_out && (step < `ACRPC_SAMPLE_STEPS);
	assign done_out = q.done;
	assign code_out = q.code;
	assign res_out = q.res;

endmodule : acrpc_sar

/* File: hw/acrpc_top.sv */
/*
 * Converter control block: conversion clock select, sequencing,
 * split read-only result buffer, pin isolation, Avalon-MM slave
 * and a level interrupt.
 * Assumes the analog front end drives the comparator pin and follows
 * the trial code, channel select and isolation outputs.
 */
// Functional notes
// - Conversion clock is instruction clock divided by 16, 8, 1 or 2.
// - Clock select bits sit at bit 6 and bit 4, read/write, reset zero.
// - Low register bits 3..0 read result bits 3..0, read only.
// - High register holds result bits 11..4.
// - Full result is high byte then low nibble; 8-bit uses high byte.
// - Software writes never change result buffers.
// - Reset leaves result buffers untouched.
// - Result is straight binary, zero to all ones.
// - Only the selected pin reaches the converter.
// - Each configuration bit isolates its pin's digital path.
// - Conversion is 16 steps of 4 conversion clocks.
// - Completion sets done, clears start, loads result.
// - Channel field picks input 0 to 4.
// - Global enable connects selected channel, else none.
module acrpc_top
	import acrpc_pkg::*;
(
	input  wire logic        mclk_in,             // 100 MHz clock
	input  wire logic        sys_rst_in,          // Async reset, high
	input  wire logic        ce_in,               // Clock enable
	input  wire logic [9:0]  avs_address_in,      // Byte address
	input  wire logic        avs_read_in,         // Read request
	input  wire logic        avs_write_in,        // Write request
	input  wire logic [31:0] avs_writedata_in,    // Write data
	input  wire logic [3:0]  avs_byteenable_in,   // Byte lanes
	output logic [31:0]      avs_readdata_out,    // Read data
	output logic             avs_waitrequest_out, // Stall
	input  wire logic        comp_pin_in,         // Comparator level
	output logic [4:0]       chan_sel_out,        // One-hot channel
	output logic [4:0]       dig_iso_out,         // Digital isolation
	output acrpc_pkg::acrpc_res_t dac_code_out,   // Trial code
	output logic             sample_out,          // Sampling phase
	output logic             irq_out              // Level interrupt
);
	`include "acrpc_defs.svh"

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	acrpc_top_s q, d;
	acrpc_res_t res_q;
	acrpc_res_t sar_res;
	logic       sar_busy;
	logic       sar_done;
	logic       sar_go;
	logic       sar_abort;
	logic       tick;
	logic [3:0] div_lim;
	logic [7:0] idx;
	logic       req;
	logic       wr_acc;
	logic       lane0;
	logic [7:0] wb;
	logic [4:0] chan_hot;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	assign req = avs_read_in | avs_write_in;
	assign idx = avs_address_in[9:2];
	assign lane0 = avs_byteenable_in[0] & (avs_address_in[1:0] == 2'h0);
	assign wb = avs_writedata_in[7:0];
	// A write takes effect only at the edge that sees waitrequest low
	assign wr_acc = avs_write_in & lane0 & (q.bus_st == BUS_ACK);
	// One wait state on every access
	assign avs_waitrequest_out = req & (q.bus_st != BUS_ACK);
	assign avs_readdata_out = {24'h000000, q.rdata};

	// ----------------------------------------
	// Conversion clock divider
	// ----------------------------------------
	// divisor from select field
	always_comb
	begin
		case (q.clk_sel)
			2'b00:   div_lim = `ACRPC_DIV16_LIM;
			2'b01:   div_lim = `ACRPC_DIV8_LIM;
			2'b10:   div_lim = `ACRPC_DIV1_LIM;
			2'b11:   div_lim = `ACRPC_DIV2_LIM;
			default: div_lim = `ACRPC_DIV16_LIM;
		endcase
	end

	// Tick only while converting so every conversion starts aligned
	assign tick = sar_busy && (q.div_cnt == div_lim);

	// ----------------------------------------
	// Start and stop of the sequence
	// ----------------------------------------
	// start qualification
	// The done cycle still shows start high; blocking it stops a second run
	assign sar_go = q.en & q.channel_global_enable & q.start & ~sar_busy & ~sar_done;
	assign sar_abort = ~q.en;

	// ----------------------------------------
	// Channel routing and isolation, one slice per pin
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++)
		begin : g_pin
			assign chan_hot[gi] = (q.channel_select == 3'(gi));
			assign chan_sel_out[gi] = q.channel_global_enable & chan_hot[gi];
			assign dig_iso_out[gi] = q.pin_cfg[gi];
		end
	endgenerate

	// ----------------------------------------
	// Interrupt output
	// ----------------------------------------
	assign irq_out = |(q.irq_stat & q.irq_mask);

	// ----------------------------------------
	// Next state of the control block
	// ----------------------------------------
	always_comb
	begin
		d = q;

		// Comparator passes two flops before any logic reads it
		d.comp_s1 = comp_pin_in;
		d.comp_s2 = q.comp_s1;

		// Divider counts only during a conversion
		if (!sar_busy || tick)
			d.div_cnt = 4'h0;
		else
			d.div_cnt = q.div_cnt + 4'h1;

		// Bus handshake: capture read data, then answer
		case (q.bus_st)
			BUS_IDLE:
			begin
				if (req)
				begin
					d.bus_st = BUS_ACK;
					d.rdata = 8'h00;
					if (avs_address_in[1:0] == 2'h0)
					begin
						case (idx)
							`ACRPC_IDX_PIN_CFG:
								d.rdata = {3'h0, q.pin_cfg};
							`ACRPC_IDX_CTRL:
								d.rdata = {q.en, q.start, q.done, q.channel_global_enable,
									1'b0, q.channel_select};
							`ACRPC_IDX_RES_HI:
								d.rdata = res_q[11:4];
							`ACRPC_IDX_CLK_RES_LO:
								d.rdata = {1'b0, q.clk_sel[1], 1'b0,
									q.clk_sel[0], res_q[3:0]};
							`ACRPC_IDX_IRQ_STAT:
								d.rdata = {6'h00, q.irq_stat};
							`ACRPC_IDX_IRQ_MASK:
								d.rdata = {6'h00, q.irq_mask};
							default:
								d.rdata = 8'h00;
						endcase
					end
				end
			end
			BUS_ACK:
			begin
				d.bus_st = BUS_IDLE;
			end
			default:
			begin
				d.bus_st = BUS_IDLE;
			end
		endcase

		// Software writes; result bits have no write path at all
		if (wr_acc)
		begin
			case (idx)
				`ACRPC_IDX_PIN_CFG:
					d.pin_cfg = wb[4:0];
				`ACRPC_IDX_CTRL:
				begin
					d.en = wb[`ACRPC_CTRL_EN];
					d.start = wb[`ACRPC_CTRL_START];
					d.done = wb[`ACRPC_CTRL_DONE];
					d.channel_global_enable = wb[`ACRPC_CTRL_CHANNEL_GLOBAL_ENABLE];
					d.channel_select = wb[2:0];
				end
				`ACRPC_IDX_CLK_RES_LO:
					d.clk_sel = {wb[`ACRPC_CLK_SEL_HI], wb[`ACRPC_CLK_SEL_LO]};
				`ACRPC_IDX_IRQ_STAT:
					d.irq_stat = q.irq_stat & ~wb[1:0];
				`ACRPC_IDX_IRQ_MASK:
					d.irq_mask = wb[1:0];
				default:
				begin
				end
			endcase
		end

		// A new conversion shows as progressing
		if (sar_go)
			d.done = 1'b0;

		// Abort drops the request so it does not restart on re-enable
		if (sar_busy && sar_abort)
		begin
			d.start = 1'b0;
			d.irq_stat[`ACRPC_IRQ_ABORT] = 1'b1;
		end

		// Hardware events win over a clearing write in the same cycle
		// done set, start cleared
		if (sar_done)
		begin
			d.done = 1'b1;
			d.start = 1'b0;
			d.irq_stat[`ACRPC_IRQ_DONE] = 1'b1;
		end
	end

	// ----------------------------------------
	// Control state register
	// ----------------------------------------
	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			q <= '0;
			q.bus_st <= BUS_IDLE;
			q.rdata <= `ACRPC_RST_BYTE;
		end
		else if (ce_in)
		begin
			q <= d;
		end
	end

	// ----------------------------------------
	// Result buffer
	// ----------------------------------------
	// no reset term
	// twelve bits with done
	// Kept out of the reset struct; it powers up unknown by design
	always_ff @(posedge mclk_in)
	begin
		if (ce_in && sar_done)
			res_q <= sar_res;
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// sixteen step sequence
	acrpc_sar u_sar (
		.mclk_in    (mclk_in),
		.sys_rst_in (sys_rst_in),
		.ce_in      (ce_in),
		.tick_in    (tick),
		.go_in      (sar_go),
		.abort_in   (sar_abort),
		.comp_in    (q.comp_s2),
		.busy_out   (sar_busy),
		.sample_out (sample_out),
		.done_out   (sar_done),
		.code_out   (dac_code_out),
		.res_out    (sar_res)
	);

endmodule : acrpc_top

/* File: tb/acrpc_monitor.sv */
/* Port checker of the converter control block.
   Assumes ce_in stays high while traffic runs. */
module acrpc_monitor
	import acrpc_pkg::*;
(
	input wire logic        mclk_in,             // Clock
	input wire logic        sys_rst_in,          // Reset
	input wire logic        ce_in,               // Enable
	input wire logic [9:0]  avs_address_in,      // Address
	input wire logic        avs_read_in,         // Read
	input wire logic        avs_write_in,        // Write
	input wire logic [31:0] avs_writedata_in,    // Data
	input wire logic [3:0]  avs_byteenable_in,   // Lanes
	input wire logic [31:0] avs_readdata_out,    // Read data
	input wire logic        avs_waitrequest_out, // Stall
	input wire logic [4:0]  chan_sel_out,        // Route
	input wire logic [4:0]  dig_iso_out,         // Isolation
	input wire acrpc_pkg::acrpc_res_t dac_code_out, // Trial
	input wire logic        sample_out,          // Sampling
	input wire logic        irq_out              // Interrupt
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       wr_ok;   // Accepted write
	logic [4:0] route_w; // Route a control write asks for
	// ----------------------------------------
	// Decode; a lane-less write is refused, so it is no cause
	// ----------------------------------------
	assign wr_ok = ce_in & avs_write_in & ~avs_waitrequest_out & avs_byteenable_in[0];
	assign route_w = avs_writedata_in[4] ? 5'h01 << avs_writedata_in[2:0] : 5'h00;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);
	a_wait_single:
	assert property (ce_in && (avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out) else $error("no answer after one wait");
	a_idle_nowait:
	assert property (!avs_read_in && !avs_write_in |-> !avs_waitrequest_out)
		else $error("stall without request");
	a_unmapped_zero:
	assert property (avs_read_in && !avs_waitrequest_out
		&& !(avs_address_in[9:2] inside {8'hAE, 8'hB1, 8'hB2, 8'hB3, 8'hC0, 8'hC1})
		|-> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
	a_rdata_upper:
	assert property (avs_readdata_out[31:8] == 24'h0) else $error("upper read bits set");
	a_iso_follow:
	assert property (wr_ok && avs_address_in == 10'h2B8
		|-> ##2 dig_iso_out == $past(avs_writedata_in[4:0], 2)) else $error("isolation wrong");
	a_chan_route:
	assert property (wr_ok && avs_address_in == 10'h2C4
		|-> ##2 chan_sel_out == $past(route_w, 2)) else $error("routing wrong");
	a_chan_single:
	assert property ($onehot0(chan_sel_out)) else $error("two pins routed");
	a_sample_mid:
	assert property (sample_out |-> dac_code_out == 12'h800) else $error("trial moved early");
	a_sample_len:
	assert property ($rose(sample_out) |-> sample_out [*8]) else $error("sampling too short");
	a_mask_quiet:
	assert property (wr_ok && avs_address_in == 10'h304 && avs_writedata_in[1:0] == 2'h0
		|-> ##2 !irq_out) else $error("masked interrupt seen");
	c_sample: cover property ($rose(sample_out));
	c_irq: cover property ($rose(irq_out));
	c_route: cover property (wr_ok && avs_address_in == 10'h2C4);
endmodule : acrpc_monitor

bind acrpc_top acrpc_monitor u_mon (.mclk_in, .sys_rst_in, .ce_in, .avs_address_in,
	.avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
	.avs_waitrequest_out, .chan_sel_out, .dig_iso_out, .dac_code_out, .sample_out, .irq_out);

/* File: tb/acrpc_afe_model.sv */
/* Analog front end: hold capacitor and comparator.
   Assumes one-hot routing from the block. */
module acrpc_afe_model
	import acrpc_pkg::*;
(
	input  wire logic        mclk_in,     // Clock
	input  wire logic [4:0]  chan_sel_in, // Route
	input  wire logic        sample_in,   // Sampling
	input  wire acrpc_pkg::acrpc_res_t dac_code_in, // Trial
	input  wire logic [59:0] level_in,    // Pin levels
	output logic             comp_pin_out // Input >= trial
);
	timeunit 1ns;
	timeprecision 1ps;
	acrpc_res_t pick;   // Routed pin level
	acrpc_res_t held_q; // Charge kept while bits are decided
	always_comb
	begin
		pick = 12'h000;
		for (int i = 0; i < 5; i++)
			if (chan_sel_in[i])
				pick = level_in[i*12 +: 12];
	end
	always_ff @(posedge mclk_in)
		if (sample_in)
			held_q <= pick;
	assign comp_pin_out = held_q >= dac_code_in;
endmodule : acrpc_afe_model

/* File: tb/test_adc_clock_result_pin_control.sv */
/* Self-checking bench of the converter control block.
   Assumes the front-end model drives the comparator. */
module test_adc_clock_result_pin_control import acrpc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_in, sys_rst_in, avs_read_in, avs_write_in, avs_waitrequest_out;
	logic comp_pin_in, sample_out, irq_out, ce_in;
	logic [9:0] avs_address_in;
	logic [31:0] avs_writedata_in, avs_readdata_out;
	logic [3:0] avs_byteenable_in;
	logic [4:0] chan_sel_out, dig_iso_out;
	acrpc_res_t dac_code_out, lv;
	logic [59:0] lvl;
	logic [7:0] q, hi;
	logic [7:0] rv [5] = '{8'hAE, 8'hB1, 8'hC0, 8'hC1, 8'hB3};
	int errors, comparisons, n, ch;
	acrpc_top u_dut (.mclk_in, .sys_rst_in, .ce_in, .avs_address_in, .avs_read_in,
		.avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
		.avs_waitrequest_out, .comp_pin_in, .chan_sel_out, .dig_iso_out, .dac_code_out,
		.sample_out, .irq_out);
	acrpc_afe_model u_afe (.mclk_in, .chan_sel_in(chan_sel_out), .sample_in(sample_out),
		.dac_code_in(dac_code_out), .level_in(lvl), .comp_pin_out(comp_pin_in));
	// ----------------------------------------
	// Expectations and bus access
	// ----------------------------------------
	function automatic logic [4:0] f_route(input logic [3:0] c);
		return (c[3] && c[2:0] < 3'h5) ? 5'h01 << c[2:0] : 5'h00;
	endfunction : f_route
	function automatic int f_div(input logic [1:0] s);
		return s == 2'h0 ? 16 : s == 2'h1 ? 8 : s == 2'h2 ? 1 : 2;
	endfunction : f_div
	task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string m);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic chk_time(input int got, input int exp);
		comparisons++;
		if (got < exp - 2 || got > exp + 6)
		begin
			errors++;
			$display("BAD %0t run took %0d exp %0d", $time, got, exp);
		end
	endtask : chk_time
	// Request held until the edge that sees the stall low
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int k;
		k = 0;
		avs_address_in <= {idx, 2'h0};
		avs_writedata_in <= {24'h0, d};
		avs_write_in <= w;
		avs_read_in <= !w;
		do @(posedge mclk_in); while (avs_waitrequest_out !== 1'b0 && ++k < 50);
		if (k >= 50)
		begin
			errors++;
			$display("BAD %0t bus no answer", $time);
		end
		q = avs_readdata_out[7:0];
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		@(posedge mclk_in);
	endtask : bus
	task automatic print_verdict;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict
	initial
	begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end
	initial
	begin
		#400000;
		errors++;
		$display("BAD %0t watchdog expired", $time);
		print_verdict();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		{sys_rst_in, avs_read_in, avs_write_in, avs_address_in} = {1'b1, 12'h0};
		avs_writedata_in = 32'h0;
		avs_byteenable_in = 4'hF;
		ce_in = 1'b1;
		void'($urandom(32'h81f9));
		lvl = 60'({$urandom(), $urandom()});
		repeat (4) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		@(posedge mclk_in);
		foreach (rv[i])
		begin
			bus(0, rv[i], 8'h00);
			chk(12'(q & (i == 4 ? 8'hF0 : 8'hFF)), 12'h000, "reset");
		end
		bus(0, 8'h10, 8'h00);
		chk(12'(q), 12'h000, "unmapped");
		$display("end reset");
		lv = 12'($urandom());
		bus(1, 8'hAE, lv[7:0]);
		bus(0, 8'hAE, 8'h00);
		chk(12'(q), 12'(lv[4:0]), "pin cfg");
		chk(12'(dig_iso_out), 12'(lv[4:0]), "iso");
		bus(1, 8'hAE, 8'h00);
		avs_byteenable_in <= 4'h0;
		bus(1, 8'hAE, 8'h1F);
		avs_byteenable_in <= 4'hF;
		bus(0, 8'hAE, 8'h00);
		chk(12'(q), 12'h000, "lane off");
		for (int c = 0; c < 16; c++)
		begin
			bus(1, 8'hB1, {3'h0, c[3], 1'b0, c[2:0]});
			chk(12'(chan_sel_out), 12'(f_route(4'(c))), "route");
		end
		$display("end routing");
		bus(1, 8'hB1, 8'h80);
		repeat (10000) @(posedge mclk_in);
		bus(1, 8'hC1, 8'h03);
		for (int s = 0; s < 4; s++)
		begin
			ch = $urandom_range(4);
			lv = s == 0 ? 12'h000 : s == 1 ? 12'hFFF : 12'($urandom());
			lvl[ch*12 +: 12] = lv;
			bus(1, 8'hB3, {1'b0, s[1], 1'b0, s[0], 4'h0});
			bus(1, 8'hB1, 8'h90 | 8'(ch));
			bus(1, 8'hB1, 8'hD0 | 8'(ch));
			n = 0;
			while (irq_out !== 1'b1 && n < 3000)
			begin
				@(posedge mclk_in);
				n++;
				// Freeze ten edges of the fastest run; it must finish that much later
				ce_in <= !(s == 2 && n >= 8 && n < 18);
			end
			chk_time(n, 64 * f_div(2'(s)) + (s == 2 ? 10 : 0));
			bus(0, 8'hB2, 8'h00);
			hi = q;
			bus(0, 8'hB3, 8'h00);
			chk({hi, q[3:0]}, lv, "result");
			chk(12'(q & 8'hF0), 12'({s[1], 1'b0, s[0], 4'h0}), "clk sel");
			chk(12'({hi, q[3:2]}), lv >> 2, "ten bit");
			bus(0, 8'hB1, 8'h00);
			chk(12'(q & 8'h60), 12'h020, "done");
			bus(1, 8'hC0, 8'h01);
			chk(12'(irq_out), 12'h000, "irq clear");
			$display("end conversion %0d", s);
		end
		bus(1, 8'hB2, 8'h5A);
		bus(1, 8'hB3, 8'h0F);
		bus(0, 8'hB2, 8'h00);
		hi = q;
		bus(0, 8'hB3, 8'h00);
		chk({hi, q[3:0]}, lv, "read only");
		bus(1, 8'hB1, 8'hD0);
		repeat (100) @(posedge mclk_in);
		bus(1, 8'hB1, 8'h10);
		bus(0, 8'hC0, 8'h00);
		chk(12'(q), 12'h002, "abort");
		chk(12'(irq_out), 12'h001, "abort irq");
		bus(0, 8'hB1, 8'h00);
		chk(12'(q & 8'h40), 12'h000, "abort start");
		bus(1, 8'hC1, 8'h00);
		chk(12'(irq_out), 12'h000, "masked");
		bus(1, 8'hC0, 8'h03);
		bus(1, 8'hB1, 8'h50);
		repeat (200) @(posedge mclk_in);
		// Enable and start without the global channel bit must not convert either
		bus(1, 8'hB1, 8'hC0);
		repeat (200) @(posedge mclk_in);
		bus(0, 8'hC0, 8'h00);
		chk(12'(q), 12'h000, "no enable");
		$display("end abort");
		print_verdict();
	end
endmodule : test_adc_clock_result_pin_control
